// file: ld_enable_lock_ctl.sv
// Logical device control bank with host enables and serial-side locks
`timescale 1ns/10ps
`include "cfg_defines.svh"
module ld_enable_lock_ctl
  import cfg_pkg::*;
#(
  parameter int         NLD      = 4,
  parameter int         RT_BITS  = 3,
  parameter logic [3:0] VSB_MASK = 4'h8,
  parameter logic [7:0] PART_ID  = 8'hA5, // Arbitrary value
  parameter logic [7:0] REV_ID   = 8'h01  // Arbitrary value
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Power-up or hardware reset and host software reset pulses
  input  wire logic             hw_reset,
  input  wire logic             host_sw_reset,
  // Strap pin
  input  wire logic             config_base_strap,
  // Host configuration port
  input  wire logic             cfg_wr,
  input  wire logic             cfg_rd,
  input  wire logic [7:0]       cfg_index,
  input  wire logic [7:0]       cfg_wdata,
  output logic      [7:0]       cfg_rdata_ff,
  output logic      [7:0]       cfg_port_base_ff,
  // Serial-side register port
  input  wire logic             ec_wr,
  input  wire logic [1:0]       ec_addr,
  input  wire logic [7:0]       ec_wdata,
  output logic      [7:0]       ec_rdata_ff,
  // Host runtime cycle request
  input  wire logic             rt_req,
  input  wire logic [15:0]      rt_addr,
  output logic                  rt_sync_ff,
  output logic      [NLD-1:0]   rt_sel_ff,
  output logic                  rt_lock_resp_ff,
  output lock_mode_t            rt_lock_mode_ff,
  // Wake control unit fast-disable bits
  input  wire logic [NLD-1:0]   wake_ctl_fast_disable,
  // Module requests and gated outputs
  input  wire logic [NLD-1:0]   irq_in,
  input  wire logic [NLD-1:0]   dma_in,
  input  wire logic             expansion_irq,
  output logic      [NLD-1:0]   irq_out_ff,
  output logic      [NLD-1:0]   dma_out_ff,
  output logic                  expansion_irq_ff,
  // Module enables
  output logic      [NLD-1:0]   module_en_ff,
  output logic      [NLD-1:0]   clk_en_ff,
  output logic                  legacy_rst_ff
);
  logic [7:0]     ldn_ff;
  logic [7:0]     device_config_1_ff;
  logic [7:0]     legacy_fast_disable_cfg_ff;
  logic [NLD-1:0] access_lock_ff;
  logic [NLD-1:0] serial_side_fast_disable_ff;
  logic [7:0]     serial_if_config_ff;
  logic           lock_violation_flag_ff;
  logic           strap_level;
  logic           sw_rst;
  logic [NLD-1:0] en;
  logic [NLD-1:0] hit;
  logic [NLD-1:0] act_v;
  logic [7:0]     ld_rdata [NLD];
  logic           sel_ok;
  logic           sel_lock;
  logic           sel_block;
  logic [7:0]     rd_val;
  logic           rt_locked_hit;
  logic           unlock_fd;
  logic [15:0]    rt_mask;

  // Hardware reset carries every software reset action along
  assign sw_rst = host_sw_reset | hw_reset;

  strap_sync u_strap (
    .clock    (clock),
    .rst      (rst),
    .pin      (config_base_strap),
    .level_ff (strap_level)
  );

  // Configuration port base chosen by the strap at hardware reset
  always_ff @(posedge clock) begin
    if (rst)
      cfg_port_base_ff <= `CFG_BASE_LOW;
    else if (hw_reset)
      cfg_port_base_ff <= strap_level ? `CFG_BASE_HIGH
                                      : `CFG_BASE_LOW;
  end

  // Selected logical device lookups
  assign sel_ok    = ldn_ff < 8'(NLD);
  assign sel_lock  = sel_ok && access_lock_ff[ldn_ff[1:0]];
  assign sel_block = sel_ok && (access_lock_ff[ldn_ff[1:0]] ||
                     serial_side_fast_disable_ff[ldn_ff[1:0]]);

  // Per-device register sets; host writes dropped while locked
  for (genvar i = 0; i < NLD; i++) begin : g_ld
    ld_cfg_if lif ();
    assign lif.wr     = cfg_wr && sel_ok && ldn_ff == 8'(i) &&
                        !access_lock_ff[i];
    assign lif.sw_rst = sw_rst;
    assign lif.idx    = cfg_index;
    assign lif.wdata  = cfg_wdata;
    assign ld_rdata[i] = lif.rdata;
    assign act_v[i]   = lif.act;
    ld_regs u_regs (
      .clock (clock),
      .rst   (rst),
      .cfg   (lif.regs)
    );
    // Runtime window decode on the primary base
    assign hit[i] = rt_req && ((rt_addr & rt_mask) ==
                    (lif.base0 & rt_mask));
  end

  assign rt_mask = 16'hFFFF << RT_BITS;

  // Host control path versus serial-side lock path
  always_comb begin
    for (int i = 0; i < NLD; i++) begin
      if (access_lock_ff[i])
        en[i] = !serial_side_fast_disable_ff[i];
      else
        en[i] = act_v[i] && device_config_1_ff[`BIT_GLOBAL_ENABLE_BIT] &&
                !legacy_fast_disable_cfg_ff[i] &&
                !wake_ctl_fast_disable[i];
    end
  end

  // Logical device number select
  always_ff @(posedge clock) begin
    if (rst || sw_rst)
      ldn_ff <= `RST_BYTE;
    else if (cfg_wr && cfg_index == `IDX_LDN)
      ldn_ff <= cfg_wdata;
  end

  // Global enable register
  always_ff @(posedge clock) begin
    if (rst || sw_rst)
      device_config_1_ff <= `RST_CFG1;
    else if (cfg_wr && cfg_index == `IDX_CFG1)
      device_config_1_ff <= cfg_wdata;
  end

  // Fast-disable bits with their sticky lock
  assign unlock_fd = ec_wr && ec_addr == `EC_CONFIG &&
                     ec_wdata[`ECB_UNLOCK_FD];
  always_ff @(posedge clock) begin
    if (rst)
      legacy_fast_disable_cfg_ff <= `RST_BYTE;
    else if (hw_reset &&
             !serial_if_config_ff[`ECB_LCSRC])
      legacy_fast_disable_cfg_ff[`BIT_FD_LOCK] <= 1'b0;
    else if (unlock_fd)
      legacy_fast_disable_cfg_ff[`BIT_FD_LOCK] <= 1'b0;
    else if (cfg_wr && cfg_index == `IDX_FD6 &&
             !legacy_fast_disable_cfg_ff[`BIT_FD_LOCK])
      legacy_fast_disable_cfg_ff <= cfg_wdata;
  end

  // Host configuration read data, registered on cfg_rd
  always_comb begin
    case (cfg_index)
      `IDX_LDN:     rd_val = ldn_ff;
      `IDX_PART_ID: rd_val = PART_ID;
      `IDX_REV_ID:  rd_val = REV_ID;
      `IDX_CFG1:    rd_val = device_config_1_ff;
      `IDX_FD6:     rd_val = legacy_fast_disable_cfg_ff;
      default:      rd_val = sel_ok ? ld_rdata[ldn_ff[1:0]]
                                    : 8'h00;
    endcase
    // Blocked device may hide its activation bit
    if (cfg_index == `IDX_ACTIVATE && sel_block &&
        !serial_if_config_ff[`ECB_READBACK])
      rd_val = 8'h00;
  end

  always_ff @(posedge clock) begin
    if (rst)
      cfg_rdata_ff <= 8'h00;
    else if (cfg_rd)
      cfg_rdata_ff <= rd_val;
  end

  // Serial-side lock, fast-disable and config registers
  always_ff @(posedge clock) begin
    if (rst) begin
      access_lock_ff              <= '0;
      serial_side_fast_disable_ff <= '0;
      serial_if_config_ff         <= `RST_BYTE;
    end else if (ec_wr) begin
      case (ec_addr)
        `EC_LOCK:   access_lock_ff <= ec_wdata[NLD-1:0];
        `EC_SFD:    serial_side_fast_disable_ff <= ec_wdata[NLD-1:0];
        `EC_CONFIG: serial_if_config_ff <= {4'h0, ec_wdata[3:0]};
        default: ;
      endcase
    end
  end

  // Violation flag: a new violation beats a clear in the same cycle
  assign rt_locked_hit = |(hit & access_lock_ff);
  always_ff @(posedge clock) begin
    if (rst)
      lock_violation_flag_ff <= 1'b0;
    else if (rt_locked_hit)
      lock_violation_flag_ff <= 1'b1;
    else if (ec_wr && ec_addr == `EC_STATUS && ec_wdata[`ECB_VIOL])
      lock_violation_flag_ff <= 1'b0;
  end

  // Serial-side read data
  always_ff @(posedge clock) begin
    if (rst)
      ec_rdata_ff <= 8'h00;
    else begin
      case (ec_addr)
        `EC_LOCK:   ec_rdata_ff <= 8'(access_lock_ff);
        `EC_SFD:    ec_rdata_ff <= 8'(serial_side_fast_disable_ff);
        `EC_CONFIG: ec_rdata_ff <= serial_if_config_ff;
        default:    ec_rdata_ff <= {7'h00, lock_violation_flag_ff};
      endcase
    end
  end

  // Runtime cycle claim; disabled devices never claim, but a locked one still raises the lock response
  always_ff @(posedge clock) begin
    if (rst) begin
      rt_sync_ff      <= 1'b0;
      rt_sel_ff       <= '0;
      rt_lock_resp_ff <= 1'b0;
      rt_lock_mode_ff <= LOCK_IGNORE;
    end else begin
      rt_sel_ff       <= hit & en & ~access_lock_ff;
      rt_sync_ff      <= |(hit & en & ~access_lock_ff);
      rt_lock_resp_ff <= rt_locked_hit;
      rt_lock_mode_ff <= lock_mode_t'(
        serial_if_config_ff[`ECB_MODE_LO +: 2]);
    end
  end

  // Resource gating and clocks
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_out_ff       <= '0;
      dma_out_ff       <= '0;
      module_en_ff     <= '0;
      clk_en_ff        <= '0;
      expansion_irq_ff <= 1'b0;
    end else begin
      irq_out_ff   <= irq_in & en & ~access_lock_ff;
      dma_out_ff   <= dma_in & en & ~access_lock_ff;
      module_en_ff <= en;
      // Standby modules keep clocking to save their state
      clk_en_ff    <= en | VSB_MASK[NLD-1:0];
      expansion_irq_ff <= expansion_irq;
    end
  end

  // Legacy module reset pulse
  always_ff @(posedge clock) begin
    if (rst)
      legacy_rst_ff <= 1'b1;
    else
      legacy_rst_ff <= sw_rst;
  end

  a_lock_gates_irq: assert property (@(posedge clock) disable iff (rst)
    (access_lock_ff[0] && irq_in[0]) |=> !irq_out_ff[0])
    else $error("locked module drove an irq");
  a_host_enable: assert property (@(posedge clock) disable iff (rst)
    (!access_lock_ff[0] && !act_v[0]) |=> !module_en_ff[0])
    else $error("inactive module enabled");
  a_ec_enable: assert property (@(posedge clock) disable iff (rst)
    (access_lock_ff[0] && !serial_side_fast_disable_ff[0])
      |=> module_en_ff[0])
    else $error("locked module not enabled");
  a_viol_sets: assert property (@(posedge clock) disable iff (rst)
    rt_locked_hit |=> lock_violation_flag_ff && rt_lock_resp_ff)
    else $error("violation not flagged");
  a_no_sync_off: assert property (@(posedge clock) disable iff (rst)
    (rt_req && en == '0) |=> !rt_sync_ff)
    else $error("disabled module claimed cycle");
  a_strap_base: assert property (@(posedge clock) disable iff (rst)
    hw_reset |=> cfg_port_base_ff ==
      ($past(strap_level) ? `CFG_BASE_HIGH : `CFG_BASE_LOW))
    else $error("wrong config base");
  a_lock_clear: assert property (@(posedge clock) disable iff (rst)
    (hw_reset && !serial_if_config_ff[`ECB_LCSRC])
      |=> !legacy_fast_disable_cfg_ff[`BIT_FD_LOCK])
    else $error("lock survived hardware reset");
  a_sw_reset: assert property (@(posedge clock) disable iff (rst)
    sw_rst |=> legacy_rst_ff ##1 (module_en_ff & ~access_lock_ff) == '0)
    else $error("software reset left module enabled");
  a_read_hide: assert property (@(posedge clock) disable iff (rst)
    (cfg_rd && cfg_index == `IDX_ACTIVATE && sel_block &&
     !serial_if_config_ff[`ECB_READBACK]) |=> cfg_rdata_ff == 8'h00)
    else $error("blocked activation bit visible");
endmodule // ld_enable_lock_ctl

// file: cfg_defines.svh
// Index, field and reset constants of the configuration register bank
`ifndef CFG_DEFINES_SVH
`define CFG_DEFINES_SVH
`define IDX_LDN        8'h07
`define IDX_PART_ID    8'h20
`define IDX_CFG1       8'h21
`define IDX_FD6        8'h26
`define IDX_REV_ID     8'h27
`define IDX_ACTIVATE   8'h30
`define IDX_BASE0_HI   8'h60
`define IDX_BASE0_LO   8'h61
`define IDX_BASE1_HI   8'h62
`define IDX_BASE1_LO   8'h63
`define IDX_IRQ_NUM    8'h70
`define IDX_IRQ_TYPE   8'h71
`define IDX_DMA0       8'h74
`define IDX_DMA1       8'h75
`define BIT_ACTIVATE   0
`define BIT_GLOBAL_ENABLE_BIT     0
`define BIT_FD_LOCK    7
`define RST_BYTE       8'h00
`define RST_BASE       16'h0000
`define RST_DMA        8'h04
`define RST_CFG1       8'h01
`define CFG_BASE_LOW   8'h2E
`define CFG_BASE_HIGH  8'h4E
`define MASK_IRQ_TYPE  8'h03
`define MASK_DMA       8'h07
`define EC_LOCK        2'h0
`define EC_SFD         2'h1
`define EC_CONFIG      2'h2
`define EC_STATUS      2'h3
`define ECB_MODE_LO    0
`define ECB_READBACK   2
`define ECB_LCSRC      3
`define ECB_UNLOCK_FD  4
`define ECB_VIOL       0
`endif

// file: cfg_pkg.sv
// Shared types of the logical device control bank
package cfg_pkg;
  // Completion of a host runtime cycle aimed at a locked module
  typedef enum logic [1:0] {
    LOCK_IGNORE,
    LOCK_SYNC_ONES,
    LOCK_SYNC_DROP,
    LOCK_SYNC_ERROR
  } lock_mode_t;
endpackage

// file: ld_cfg_if.sv
// Carrier between the bank and one logical device register set
`timescale 1ns/10ps
interface ld_cfg_if;
  logic        wr;
  logic        sw_rst;
  logic [7:0]  idx;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        act;
  logic [15:0] base0;
  logic [15:0] base1;
  logic [7:0]  irq_sel;
  logic [7:0]  irq_type;
  logic [7:0]  dma0;
  logic [7:0]  dma1;
  modport regs (input wr, sw_rst, idx, wdata,
                output rdata, act, base0, base1, irq_sel, irq_type,
                dma0, dma1);
  modport ctl  (output wr, sw_rst, idx, wdata,
                input rdata, act, base0, base1, irq_sel, irq_type,
                dma0, dma1);
endinterface // ld_cfg_if

// file: ld_regs.sv
// Standard configuration registers of one logical device
`timescale 1ns/10ps
`include "cfg_defines.svh"
module ld_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bank side
  ld_cfg_if.regs   cfg
);
  logic        act_ff;
  logic [15:0] base0_ff;
  logic [15:0] base1_ff;
  logic [7:0]  irq_ff;
  logic [7:0]  type_ff;
  logic [7:0]  dma0_ff;
  logic [7:0]  dma1_ff;

  // Register writes; software reset restores defaults
  always_ff @(posedge clock) begin
    if (rst || cfg.sw_rst) begin
      act_ff   <= 1'b0;
      base0_ff <= `RST_BASE;
      base1_ff <= `RST_BASE;
      irq_ff   <= `RST_BYTE;
      type_ff  <= `RST_BYTE;
      dma0_ff  <= `RST_DMA;
      dma1_ff  <= `RST_DMA;
    end else if (cfg.wr) begin
      case (cfg.idx)
        `IDX_ACTIVATE: act_ff          <= cfg.wdata[`BIT_ACTIVATE];
        `IDX_BASE0_HI: base0_ff[15:8]  <= cfg.wdata;
        `IDX_BASE0_LO: base0_ff[7:0]   <= cfg.wdata;
        `IDX_BASE1_HI: base1_ff[15:8]  <= cfg.wdata;
        `IDX_BASE1_LO: base1_ff[7:0]   <= cfg.wdata;
        `IDX_IRQ_NUM:  irq_ff          <= cfg.wdata;
        `IDX_IRQ_TYPE: type_ff  <= cfg.wdata & `MASK_IRQ_TYPE;
        `IDX_DMA0:     dma0_ff  <= cfg.wdata & `MASK_DMA;
        `IDX_DMA1:     dma1_ff  <= cfg.wdata & `MASK_DMA;
        default: ;
      endcase
    end
  end

  // Read mux; unknown indexes read zero
  always_comb begin
    case (cfg.idx)
      `IDX_ACTIVATE: cfg.rdata = {7'h00, act_ff};
      `IDX_BASE0_HI: cfg.rdata = base0_ff[15:8];
      `IDX_BASE0_LO: cfg.rdata = base0_ff[7:0];
      `IDX_BASE1_HI: cfg.rdata = base1_ff[15:8];
      `IDX_BASE1_LO: cfg.rdata = base1_ff[7:0];
      `IDX_IRQ_NUM:  cfg.rdata = irq_ff;
      `IDX_IRQ_TYPE: cfg.rdata = type_ff;
      `IDX_DMA0:     cfg.rdata = dma0_ff;
      `IDX_DMA1:     cfg.rdata = dma1_ff;
      default:       cfg.rdata = 8'h00;
    endcase
  end

  assign cfg.act      = act_ff;
  assign cfg.base0    = base0_ff;
  assign cfg.base1    = base1_ff;
  assign cfg.irq_sel  = irq_ff;
  assign cfg.irq_type = type_ff;
  assign cfg.dma0     = dma0_ff;
  assign cfg.dma1     = dma1_ff;

  a_swrst_clears: assert property (@(posedge clock) disable iff (rst)
    cfg.sw_rst |=> !act_ff && dma0_ff == `RST_DMA)
    else $error("software reset left device active");
endmodule // ld_regs

// file: strap_sync.sv
// Three-stage synchroniser for a pin level
`timescale 1ns/10ps
module strap_sync (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Pin and filtered level
  input  wire logic pin,
  output logic      level_ff
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // Stage one feeds only stage two
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge clock) begin
    if (rst)
      level_ff <= 1'b0;
    else if (s2_ff == s3_ff)
      level_ff <= s3_ff;
  end
endmodule // strap_sync

// file: ec_model.sv
// Embedded controller model on the serial-side register port
`timescale 1ns/10ps
module ec_model (
  // Clock
  input  wire logic       clock,
  // Serial-side register port
  output logic            ec_wr,
  output logic [1:0]      ec_addr,
  output logic [7:0]      ec_wdata
);
  initial begin
    ec_wr    = 1'b0;
    ec_addr  = 2'h0;
    ec_wdata = 8'h00;
  end

  // Control writes only, runtime registers stay untouched
  task automatic write(input logic [1:0] a, input logic [7:0] d);
    @(negedge clock);
    ec_wr    <= 1'b1;
    ec_addr  <= a;
    ec_wdata <= d;
    @(negedge clock);
    ec_wr    <= 1'b0;
    ec_wdata <= ~d; // Stale data must not look valid
  endtask

  // Move the read address, strobe stays low
  task automatic point(input logic [1:0] a);
    @(negedge clock);
    ec_addr <= a;
  endtask
endmodule // ec_model

// file: tb_ld_enable_lock_ctl.sv
// Self-checking bench of the logical device control bank
`timescale 1ns/10ps
module tb_ld_enable_lock_ctl;
  import cfg_pkg::*;
  localparam logic [7:0] PID = 8'h5C; // Arbitrary value
  localparam logic [7:0] RID = 8'h3E; // Arbitrary value
  localparam logic [7:0] IDX [8] = '{8'h60, 8'h61, 8'h62, 8'h63,
                                     8'h70, 8'h71, 8'h74, 8'h75};
  localparam logic [7:0] VAL [8] = '{8'h12, 8'h38, 8'hAB, 8'hC0,
                                     8'h05, 8'h03, 8'h01, 8'h03};
  logic             clock, rst, hw_reset, host_sw_reset;
  logic             config_base_strap, cfg_wr, cfg_rd;
  logic       [7:0] cfg_index, cfg_wdata, cfg_rdata_ff, cfg_port_base_ff;
  logic             ec_wr, rt_req, rt_sync_ff, rt_lock_resp_ff;
  logic       [1:0] ec_addr;
  logic       [7:0] ec_wdata, ec_rdata_ff, got;
  logic      [15:0] rt_addr;
  logic       [3:0] rt_sel_ff, wake_ctl_fast_disable, irq_in, dma_in;
  logic       [3:0] irq_out_ff, dma_out_ff, module_en_ff, clk_en_ff;
  logic             expansion_irq, expansion_irq_ff, legacy_rst_ff;
  lock_mode_t       rt_lock_mode_ff;
  logic       [7:0] rq[$];
  logic       [7:0] tq[$];
  int               fails, checked, rd_t, n;
  int               seed = 32'h2def4eaf;

  ld_enable_lock_ctl #(.NLD(4), .RT_BITS(3), .VSB_MASK(4'h8),
    .PART_ID(PID), .REV_ID(RID)) i_dut (
    .clock, .rst, .hw_reset, .host_sw_reset, .config_base_strap,
    .cfg_wr, .cfg_rd, .cfg_index, .cfg_wdata, .cfg_rdata_ff,
    .cfg_port_base_ff, .ec_wr, .ec_addr, .ec_wdata, .ec_rdata_ff,
    .rt_req, .rt_addr, .rt_sync_ff, .rt_sel_ff, .rt_lock_resp_ff,
    .rt_lock_mode_ff, .wake_ctl_fast_disable, .irq_in, .dma_in,
    .expansion_irq, .irq_out_ff, .dma_out_ff, .expansion_irq_ff,
    .module_en_ff, .clk_en_ff, .legacy_rst_ff);
  ec_model u_ec (.clock, .ec_wr, .ec_addr, .ec_wdata);

  // Free-running 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic idle(input int k);
    repeat (k) @(negedge clock);
  endtask

  task automatic cwr(input logic [7:0] i, input logic [7:0] d);
    @(negedge clock);
    cfg_wr    <= 1'b1;
    cfg_index <= i;
    cfg_wdata <= d;
    @(negedge clock);
    cfg_wr    <= 1'b0;
  endtask

  // Read strobe; the monitor compares two cycles on
  task automatic crd(input logic [7:0] i, input logic [7:0] e);
    @(negedge clock);
    cfg_rd    <= 1'b1;
    cfg_index <= i;
    rq.push_back(e);
    @(negedge clock);
    cfg_rd    <= 1'b0;
    @(negedge clock);
  endtask

  // Runtime cycle; e packs claim, lock, mode, selected module
  task automatic rt(input logic [7:0] e);
    @(negedge clock);
    rt_req  <= 1'b1;
    rt_addr <= {8'h12, 5'h07, 3'($random(seed))};
    if (e != 8'h00)
      tq.push_back(e);
    @(negedge clock);
    rt_req  <= 1'b0;
    n = 0;
    while (tq.size() != 0 && n < 8) begin
      @(negedge clock);
      n++;
    end
    if (tq.size() != 0) begin
      fails++; // Answer never came
      end_sim();
    end else
      idle(3); // Late stray pulses still get caught
  endtask

  // Monitor: read data and runtime answers against the oldest note
  always @(negedge clock) begin
    if (rd_t != 0) begin
      rd_t = rd_t - 1;
      if (rd_t == 0 && rq.size() != 0)
        check(cfg_rdata_ff, rq.pop_front());
    end
    if (cfg_rd === 1'b1)
      rd_t = 2;
    if (rt_sync_ff === 1'b1 || rt_lock_resp_ff === 1'b1) begin
      got = {rt_sync_ff, rt_lock_resp_ff,
             rt_lock_resp_ff ? 2'(rt_lock_mode_ff) : 2'h0,
             rt_sync_ff ? rt_sel_ff : 4'h0};
      check(got, tq.size() != 0 ? tq.pop_front() : 8'h00);
    end
  end

  initial begin
    {rst, hw_reset, host_sw_reset, config_base_strap} = 4'h8;
    {cfg_wr, cfg_rd, rt_req, expansion_irq} = 4'h0;
    {cfg_index, cfg_wdata, rt_addr} = 32'h0;
    {wake_ctl_fast_disable, irq_in, dma_in} = 12'h000;
    {fails, checked, rd_t} = 0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    rst <= 1'b0;
    idle(4);
    check(cfg_port_base_ff, 8'h2E);
    config_base_strap <= 1'b1;
    idle(5); // Strap synchroniser settles first
    hw_reset <= 1'b1;
    idle(1);
    hw_reset <= 1'b0;
    idle(2);
    check(cfg_port_base_ff, 8'h4E);
    crd(8'h20, PID);
    crd(8'h27, RID);
    cwr(8'h07, 8'h00);
    crd(8'h30, 8'h00);
    for (int k = 0; k < 8; k++)
      cwr(IDX[k], VAL[k]);
    for (int k = 0; k < 8; k++)
      crd(IDX[k], VAL[k]);
    rt(8'h00);
    cwr(8'h30, 8'h01);
    idle(3);
    check({module_en_ff[0], clk_en_ff[0]}, 2'h3);
    rt(8'h81);
    irq_in <= 4'($random(seed)) | 4'h1;
    dma_in <= 4'($random(seed)) | 4'h1;
    idle(3);
    check({irq_out_ff, dma_out_ff}, 8'h11);
    // Host fast-disable drops the legacy module, standby keeps its clock
    wake_ctl_fast_disable <= 4'h1;
    expansion_irq <= 1'b1;
    idle(3);
    check({module_en_ff[0], clk_en_ff[0], irq_out_ff[0]}, 3'h0);
    check({clk_en_ff[3], expansion_irq_ff}, 2'h3);
    rt(8'h00);
    wake_ctl_fast_disable <= 4'h0;
    cwr(8'h21, 8'h00);
    idle(3);
    check(module_en_ff[0], 1'b0);
    cwr(8'h21, 8'h01);
    // Serial lock takes over; host disables are ignored
    u_ec.write(2'h0, 8'h01);
    wake_ctl_fast_disable <= 4'h1;
    idle(3);
    check({module_en_ff[0], irq_out_ff[0], dma_out_ff[0]}, 3'h4);
    cwr(8'h70, 8'h0A);
    crd(8'h70, 8'h05);
    for (int m = 0; m < 4; m++) begin
      u_ec.write(2'h2, 8'(m));
      rt({2'h1, 2'(m), 4'h0});
    end
    u_ec.point(2'h3);
    idle(2);
    check(ec_rdata_ff[0], 1'b1);
    u_ec.write(2'h1, 8'h01);
    idle(3);
    check(module_en_ff[0], 1'b0);
    u_ec.write(2'h2, 8'h00);
    crd(8'h30, 8'h00);
    u_ec.write(2'h2, 8'h04);
    crd(8'h30, 8'h01);
    // Fast-disable lock refuses host writes
    wake_ctl_fast_disable <= 4'h0;
    cwr(8'h26, 8'h80);
    cwr(8'h26, 8'h01);
    crd(8'h26, 8'h80);
    // Lock clear source select at 1 keeps the lock over hardware reset
    u_ec.write(2'h2, 8'h0C);
    hw_reset <= 1'b1;
    idle(1);
    hw_reset <= 1'b0;
    crd(8'h26, 8'h80);
    // Serial unlock strobe, relock, then reset with select at 0
    u_ec.write(2'h2, 8'h14);
    crd(8'h26, 8'h00);
    cwr(8'h26, 8'h80);
    hw_reset <= 1'b1;
    idle(1);
    hw_reset <= 1'b0;
    crd(8'h26, 8'h00);
    crd(8'h30, 8'h00);
    crd(8'h60, 8'h00);
    // Host software reset after fresh settings on an unlocked device
    u_ec.write(2'h0, 8'h00);
    idle(2);
    check(ec_rdata_ff, 8'h00);
    cwr(8'h30, 8'h01);
    cwr(8'h74, 8'h01);
    crd(8'h30, 8'h01);
    crd(8'h74, 8'h01);
    host_sw_reset <= 1'b1;
    idle(1);
    host_sw_reset <= 1'b0;
    n = 0;
    while (legacy_rst_ff !== 1'b1 && n < 4) begin
      @(negedge clock);
      n++;
    end
    check(legacy_rst_ff, 1'b1);
    crd(8'h30, 8'h00);
    crd(8'h74, 8'h04);
    crd(8'h61, 8'h00);
    idle(3);
    end_sim();
  end
endmodule // tb_ld_enable_lock_ctl
